/* logic/qosc_regs.vh */
// register map, field layout and encodings of the priority classifier
`ifndef QOSC_REGS_VH
`define QOSC_REGS_VH

`define QOSC_ADDR_W 12
`define QOSC_OFF_CTRL 12'h000
`define QOSC_OFF_STATUS 12'h004
`define QOSC_OFF_FILL 12'h008
`define QOSC_OFF_TAG_TBL 12'h00C
`define QOSC_OFF_DSCP_LO 12'h010
`define QOSC_OFF_DSCP_HI 12'h014
`define QOSC_OFF_ENTRY 12'h018

`define QOSC_MODE_W 2
`define QOSC_MODE_OFF 2'h0
`define QOSC_MODE_TAG 2'h1
`define QOSC_MODE_DSCP 2'h2

`define QOSC_CTRL_MODE_LSB 0
`define QOSC_CTRL_DEF_BIT 4

`define QOSC_FILL_GO_BIT 0
`define QOSC_FILL_VAL_BIT 1

`define QOSC_ENT_IDX_LSB 0
`define QOSC_ENT_VAL_BIT 8
`define QOSC_ENT_TBL_BIT 9

`define QOSC_TAG_N 8
`define QOSC_DSCP_N 64
`define QOSC_PRIO_NORMAL 1'h0
`define QOSC_PRIO_HIGH 1'h1

`define QOSC_RST_CTRL 32'h00000000

`endif

/* logic/qosc_table.v */
// one-bit-per-entry lookup table with bulk fill and registered read
`timescale 1ns/1ps
module qosc_table #(
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire core_clk,
  input wire rst,
  input wire wr_en,
  input wire [AW-1:0] wr_idx,
  input wire wr_val,
  input wire fill_en,
  input wire fill_val,
  input wire [AW-1:0] rd_idx,
  output reg rd_val_q,
  output wire [DEPTH-1:0] all_bits
);
  reg [DEPTH-1:0] mem_q;
  integer i;

  assign all_bits = mem_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_q <= {DEPTH{1'b0}};
      rd_val_q <= 1'b0;
    end else begin
      if (fill_en) begin
        for (i = 0; i < DEPTH; i = i + 1) begin
          mem_q[i] <= fill_val;
        end
      end else if (wr_en) begin
        mem_q[wr_idx] <= wr_val;
      end
      rd_val_q <= mem_q[rd_idx];
    end
  end
endmodule

/* logic/qosc_classifier.v */
// two-level priority classifier with APB configuration
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "qosc_regs.vh"
module qosc_classifier (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`QOSC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire frm_valid,
  output wire frm_ready,
  input wire frm_has_tag,
  input wire [2:0] frm_user_prio,
  input wire frm_is_ip,
  input wire [5:0] frm_dscp,
  output reg cls_valid_q,
  output reg cls_high_q,
  input wire cls_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  reg [`QOSC_MODE_W-1:0] mode_q;
  reg def_prio_q;
  reg [31:0] frames_q;
  wire wr_acc;
  wire rd_acc;
  wire hit;
  wire [7:0] tag_bits;
  wire [63:0] dscp_bits;

  function is_mapped;
    input [`QOSC_ADDR_W-1:0] a;
    begin
      is_mapped = (a == `QOSC_OFF_CTRL) || (a == `QOSC_OFF_STATUS) ||
                  (a == `QOSC_OFF_FILL) || (a == `QOSC_OFF_TAG_TBL) ||
                  (a == `QOSC_OFF_DSCP_LO) || (a == `QOSC_OFF_DSCP_HI) ||
                  (a == `QOSC_OFF_ENTRY);
    end
  endfunction

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign hit = is_mapped(paddr);
  assign pslverr = psel & penable & ~hit;
  assign wr_acc = psel & penable & pwrite & hit;
  assign rd_acc = psel & penable & ~pwrite;

  wire ctrl_wr = wr_acc & (paddr == `QOSC_OFF_CTRL);
  wire fill_wr = wr_acc & (paddr == `QOSC_OFF_FILL) &
                 pwdata[`QOSC_FILL_GO_BIT];
  wire ent_wr = wr_acc & (paddr == `QOSC_OFF_ENTRY);
  wire fill_val = pwdata[`QOSC_FILL_VAL_BIT];
  wire ent_dscp = pwdata[`QOSC_ENT_TBL_BIT];
  wire ent_val = pwdata[`QOSC_ENT_VAL_BIT];
  wire [5:0] ent_idx = pwdata[`QOSC_ENT_IDX_LSB +: 6];

  // bulk fill acts on the table of the mode in force; nothing when off
  wire tag_fill = fill_wr & (mode_q == `QOSC_MODE_TAG);
  wire dscp_fill = fill_wr & (mode_q == `QOSC_MODE_DSCP);
  wire tag_wr = ent_wr & ~ent_dscp;
  wire dscp_wr = ent_wr & ent_dscp;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= `QOSC_MODE_OFF;
      def_prio_q <= `QOSC_PRIO_NORMAL;
    end else if (ctrl_wr) begin
      // the reserved code is refused so exactly one mode stays selected
      if (pwdata[`QOSC_CTRL_MODE_LSB +: `QOSC_MODE_W] != 2'h3) begin
        mode_q <= pwdata[`QOSC_CTRL_MODE_LSB +: `QOSC_MODE_W];
      end
      def_prio_q <= pwdata[`QOSC_CTRL_DEF_BIT];
    end
  end

  always @* begin
    prdata = 32'h00000000;
    if (rd_acc) begin
      case (paddr)
        `QOSC_OFF_CTRL: begin
          prdata[`QOSC_CTRL_MODE_LSB +: `QOSC_MODE_W] = mode_q;
          prdata[`QOSC_CTRL_DEF_BIT] = def_prio_q;
        end
        `QOSC_OFF_STATUS: prdata = frames_q;
        `QOSC_OFF_TAG_TBL: prdata[7:0] = tag_bits;
        `QOSC_OFF_DSCP_LO: prdata = dscp_bits[31:0];
        `QOSC_OFF_DSCP_HI: prdata = dscp_bits[63:32];
        default: prdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lookup tables

  wire tag_rd;
  wire dscp_rd;
  reg [2:0] s1_prio_q;
  reg [5:0] s1_dscp_q;
  wire adv_rd;
  // a stalled stage re-reads its own key, not the waiting descriptor's
  wire [2:0] tag_idx = adv_rd ? frm_user_prio : s1_prio_q;
  wire [5:0] dscp_idx = adv_rd ? frm_dscp : s1_dscp_q;

  qosc_table #(.DEPTH(`QOSC_TAG_N), .AW(3)) u_tag_tbl (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(tag_wr),
    .wr_idx(ent_idx[2:0]),
    .wr_val(ent_val),
    .fill_en(tag_fill),
    .fill_val(fill_val),
    .rd_idx(tag_idx),
    .rd_val_q(tag_rd),
    .all_bits(tag_bits)
  );

  qosc_table #(.DEPTH(`QOSC_DSCP_N), .AW(6)) u_dscp_tbl (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(dscp_wr),
    .wr_idx(ent_idx),
    .wr_val(ent_val),
    .fill_en(dscp_fill),
    .fill_val(fill_val),
    .rd_idx(dscp_idx),
    .rd_val_q(dscp_rd),
    .all_bits(dscp_bits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // classification pipeline: table read in stage 1, decision in stage 2

  reg s1_valid_q;
  reg [`QOSC_MODE_W-1:0] s1_mode_q;
  reg s1_has_key_q;
  reg s1_def_q;
  reg cls_d;
  wire advance;

  // a stalled output stalls the parser; table reads follow the stage
  assign advance = ~cls_valid_q | cls_ready;
  assign adv_rd = advance;
  assign frm_ready = advance & ~(s1_valid_q & ~advance);

  always @* begin
    case (s1_mode_q)
      `QOSC_MODE_OFF: cls_d = s1_def_q;
      `QOSC_MODE_TAG: cls_d = s1_has_key_q ? tag_rd :
                              `QOSC_PRIO_NORMAL;
      `QOSC_MODE_DSCP: cls_d = s1_has_key_q ? dscp_rd :
                               `QOSC_PRIO_NORMAL;
      default: cls_d = `QOSC_PRIO_NORMAL;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_valid_q <= 1'b0;
      s1_mode_q <= `QOSC_MODE_OFF;
      s1_has_key_q <= 1'b0;
      s1_def_q <= `QOSC_PRIO_NORMAL;
      s1_prio_q <= 3'h0;
      s1_dscp_q <= 6'h00;
      cls_valid_q <= 1'b0;
      cls_high_q <= `QOSC_PRIO_NORMAL;
      frames_q <= 32'h00000000;
    end else if (advance) begin
      s1_valid_q <= frm_valid;
      s1_mode_q <= mode_q;
      s1_def_q <= def_prio_q;
      s1_prio_q <= frm_user_prio;
      s1_dscp_q <= frm_dscp;
      s1_has_key_q <= (mode_q == `QOSC_MODE_TAG) ? frm_has_tag : frm_is_ip;
      cls_valid_q <= s1_valid_q;
      cls_high_q <= cls_d;
      if (s1_valid_q & cls_d) begin
        frames_q <= frames_q + 32'h00000001;
      end
    end
  end

endmodule

/* sim/qosc_checker.sv */
// port checks for the priority classifier
`timescale 1ns/1ps
module qosc_checker(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic frm_valid,
  input wire logic frm_ready,
  input wire logic cls_valid_q,
  input wire logic cls_high_q,
  input wire logic cls_ready
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_out_hold: assert property (cls_valid_q && !cls_ready |=>
    cls_valid_q && $stable(cls_high_q)) else $error("stall lost");
  a_stall_block: assert property (cls_valid_q && !cls_ready |->
    !frm_ready) else $error("taken while stalled");
  a_two_cycle: assert property (frm_valid && frm_ready && cls_ready
    ##1 cls_ready |=> cls_valid_q) else $error("result late");
  a_bus_ready: assert property (psel && penable |-> pready)
    else $error("no ready");
  a_idle_zero: assert property (!(psel && penable) |->
    prdata == 32'h0) else $error("read data outside access");
  a_unmap_err: assert property (psel && penable &&
    paddr > 12'h018 |-> pslverr) else $error("no error");
  a_ctrl_ok: assert property (psel && penable &&
    paddr == 12'h000 |-> !pslverr) else $error("control refused");
  a_err_idle: assert property (!penable |-> !pslverr)
    else $error("error outside access");
endmodule
bind qosc_classifier qosc_checker u_qosc_checker(.*);

/* sim/qosc_qmgr.sv */
// queue manager model: takes results under random back-pressure
`timescale 1ns/1ps
module qosc_qmgr(
  input wire logic core_clk,
  input wire logic cls_valid_q,
  output logic cls_ready
);
  initial cls_ready = 1;
  // stalls only in a cycle after one in which a result was valid, so held results get exercised
  always @(posedge core_clk)
    cls_ready <= !cls_valid_q || $urandom % 4 != 0;
endmodule

/* sim/tb_top.sv */
// bench for the priority classifier
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, c;
  logic pready, pslverr, frm_valid = 0, frm_ready, frm_has_tag = 0;
  logic frm_is_ip = 0, cls_valid_q, cls_high_q, cls_ready, e, b, x;
  logic [2:0] frm_user_prio = 0;
  logic [5:0] frm_dscp = 0, n;
  logic [7:0] tt = 0;
  logic [63:0] dt = 0;
  logic q[$];
  int num_errors = 0, n_checks = 0, nh = 0, i, j, k;
  always #50 core_clk = ~core_clk;
  qosc_classifier u_qosc_classifier(.*);
  qosc_qmgr u_qosc_qmgr(.*);
  task summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task fail;
    num_errors++;
    summarize;
  endtask
  task chk(input string s, input logic [63:0] g, input logic [63:0] w);
    n_checks++;
    if (g !== w) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", s, w, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge core_clk);
      if (++k > 9) fail;
    end while (pready !== 1);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  task tbl;
    apb(0, 12'h00C, 0);
    chk("tag table", rd, tt);
    apb(0, 12'h010, 0);
    chk("dscp low", rd, dt[31:0]);
    apb(0, 12'h014, 0);
    chk("dscp high", rd, dt[63:32]);
  endtask
  task frm;
    logic t, p;
    logic [2:0] u;
    logic [5:0] d;
    {t, u, p, d} = 11'($urandom);
    frm_valid <= 1;
    frm_has_tag <= t;
    frm_user_prio <= u;
    frm_is_ip <= p;
    frm_dscp <= d;
    k = 0;
    do begin
      @(negedge core_clk);
      b = frm_ready;
      @(posedge core_clk);
      if (++k > 99) fail;
    end while (b !== 1);
    x = c[1:0] == 0 ? c[4] : c[0] ? t & tt[u] : p & dt[d];
    q.push_back(x);
    nh += x;
  endtask
  always @(posedge core_clk)
    if (cls_valid_q && cls_ready)
      chk("class", cls_high_q, q.pop_front());
  initial begin
    void'($urandom(46183));
    repeat (8) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    apb(0, 12'h000, 0);
    chk("ctrl", rd, 0);
    tbl;
    for (i = 0; i < 4; i++) begin
      c = i == 1 ? 32'h10 : i - (i > 1);
      apb(1, 12'h000, c);
      apb(0, 12'h000, 0);
      chk("ctrl", rd, c);
      for (j = 0; j < 2; j++) begin
        x = j ? i[0] : 1'b1;
        apb(1, 12'h008, {x, 1'b1});
        if (c[1:0] == 1) tt = {8{x}};
        if (c[1:0] == 2) dt = {64{x}};
        tbl;
      end
      repeat (8) begin
        {b, x, n} = 8'($urandom);
        if (!b) n[5:3] = 0;
        apb(1, 12'h018, {b, x, 2'h0, n});
        if (b) dt[n] = x;
        else tt[n[2:0]] = x;
      end
      tbl;
      repeat (40) frm;
      frm_valid <= 0;
      k = 0;
      while (q.size() > 0) begin
        @(posedge core_clk);
        if (++k > 999) fail;
      end
      $display("test %0d done", i);
    end
    apb(0, 12'h01C, 0);
    chk("unmapped", e, 1);
    apb(0, 12'h004, 0);
    chk("high count", rd, nh);
    summarize;
  end
endmodule
